// [rtl/swm_host.sv]
/*
  swm_host: serial master for a chain of switch monitor devices: plain
  frames, sleep entry and two-step status recovery.
  Assumes devices are chained, first device data out into the next.
*/
`timescale 1ns/1ps
module swm_host
  import swm_pkg::*;
#(
  parameter int unsigned N_DEV = N_DEV_DEF,
  parameter int unsigned HALF_CYC = SCLK_HALF_CYC,
  parameter int unsigned GAP_CYC = STATUS_GAP_CYC,
  parameter int unsigned REFR_CYC = REFRESH_CYC
)
(
  input wire logic clk,
  input wire logic reset_n,
  swm_link_if.host link,
  input wire logic frame_req,
  input wire logic [WORD_BITS*N_DEV-1:0] frame_data,
  input wire logic sleep_req,
  input wire logic acked_all,
  input wire logic recover_req,
  output logic busy_q,
  output logic done_q,
  output logic [WORD_BITS*N_DEV-1:0] rx_data_q,
  output logic wake_low_q,
  output logic refresh_due_q
);
  localparam int unsigned FB = WORD_BITS * N_DEV;
  typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_HI, ST_LO, ST_TRAIL, ST_GAP} swm_st_t;

  function automatic logic [FB-1:0] swm_all(input logic [7:0] c);
    logic [FB-1:0] w;
    w = '0;
    for (int i = 0; i < N_DEV; i++)
    begin
      w[i*WORD_BITS +: WORD_BITS] = {c, CMD_PAD};
    end
    return w;
  endfunction

  swm_st_t st_q;
  logic [31:0] hc_q;
  logic [31:0] gap_q;
  logic [31:0] ref_q;
  logic [15:0] bit_q;
  logic [FB-1:0] tx_q;
  logic [FB-1:0] rx_q;
  logic again_q;
  logic cs_n_q;
  logic sclk_q;
  logic mosi_q;
  logic [1:0] miso_s_q;
  logic [1:0] line_s_q;

  wire half_end = (hc_q == 32'(HALF_CYC - 1));
  wire gap_end = (gap_q == 32'h0);
  wire idle = (st_q == ST_IDLE);
  // sleep only once software has acknowledged every switch state
  wire take_sleep = idle & sleep_req & acked_all;
  wire take_rec = idle & ~take_sleep & recover_req;
  wire take_frame = idle & ~take_sleep & ~take_rec & frame_req;
  // one frame for the whole chain so all devices sleep together
  wire [FB-1:0] start_word = take_sleep ? swm_all(CMD_SLEEP) :
    (take_rec ? swm_all(CMD_STATUS) : frame_data);
  wire start = take_sleep | take_rec | take_frame;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      miso_s_q <= 2'h0;
      line_s_q <= 2'h3;
      wake_low_q <= 1'b0;
    end
    else
    begin
      miso_s_q <= {miso_s_q[0], link.miso};
      line_s_q <= {line_s_q[0], link.wake_line};
      wake_low_q <= ~line_s_q[1];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_q <= ST_IDLE;
      hc_q <= '0;
      gap_q <= '0;
      bit_q <= '0;
      tx_q <= '0;
      rx_q <= '0;
      again_q <= 1'b0;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      mosi_q <= 1'b0;
      done_q <= 1'b0;
      rx_data_q <= '0;
    end
    else
    begin
      done_q <= 1'b0;
      hc_q <= half_end ? 32'h0 : hc_q + 32'h1;
      unique case (st_q)
        ST_IDLE:
        begin
          hc_q <= '0;
          if (start)
          begin
            st_q <= ST_LEAD;
            tx_q <= start_word;
            mosi_q <= start_word[FB-1];
            bit_q <= 16'(FB);
            cs_n_q <= 1'b0;
            again_q <= take_rec;
          end
        end
        ST_LEAD, ST_LO:
        begin
          if (half_end)
          begin
            sclk_q <= 1'b1;
            st_q <= ST_HI;
          end
        end
        ST_HI:
        begin
          if (half_end)
          begin
            sclk_q <= 1'b0;
            // sample on the fall: device answer lags three clocks plus our sync
            rx_q <= {rx_q[FB-2:0], miso_s_q[1]};
            tx_q <= {tx_q[FB-2:0], 1'b0};
            mosi_q <= tx_q[FB-2];
            bit_q <= bit_q - 16'h1;
            st_q <= (bit_q == 16'h1) ? ST_TRAIL : ST_LO;
          end
        end
        ST_TRAIL:
        begin
          if (half_end)
          begin
            cs_n_q <= 1'b1;
            done_q <= 1'b1;
            rx_data_q <= rx_q;
            // first status after a partial sleep may be stale: settle, then ask again
            gap_q <= again_q ? 32'(GAP_CYC - 1) : 32'(CS_GAP_CYC - 1);
            st_q <= ST_GAP;
          end
        end
        ST_GAP:
        begin
          gap_q <= gap_q - 32'h1;
          if (gap_end)
          begin
            st_q <= again_q ? ST_LEAD : ST_IDLE;
            again_q <= 1'b0;
            hc_q <= '0;
            tx_q <= swm_all(CMD_STATUS);
            mosi_q <= again_q ? CMD_STATUS[7] : 1'b0;
            bit_q <= 16'(FB);
            cs_n_q <= ~again_q;
          end
        end
        default:
        begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // periodic prompt to rewrite all device configuration
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ref_q <= '0;
      refresh_due_q <= 1'b0;
    end
    else
    begin
      refresh_due_q <= (ref_q == 32'(REFR_CYC - 1));
      ref_q <= (ref_q == 32'(REFR_CYC - 1)) ? 32'h0 : ref_q + 32'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      busy_q <= 1'b0;
    end
    else
    begin
      busy_q <= ~idle | start;
    end
  end

  assign link.cs_n = cs_n_q;
  assign link.sclk = sclk_q;
  assign link.mosi = mosi_q;
endmodule

// [rtl/swm_pkg.sv]
/*
  swm_pkg: constants and types shared by the switch monitor sleep/wake
  device end and the host end.
  Assumes a single 20 MHz system clock on both ends.
*/
package swm_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned WORD_BITS = 24;
  localparam int unsigned CMD_MSB = 23;
  localparam int unsigned CMD_LSB = 16;
  localparam int unsigned CAUSE_MSB = 23;
  localparam int unsigned CAUSE_LSB = 22;
  localparam int unsigned N_GND = 14;
  localparam int unsigned N_PROG = 8;
  localparam int unsigned N_SW = 22;
  localparam logic [7:0] CMD_STATUS = 8'h00;
  localparam logic [7:0] CMD_SLEEP = 8'h01;
  localparam logic [15:0] CMD_PAD = 16'h0000;
  localparam int unsigned N_DEV_DEF = 2;
  localparam int unsigned SCLK_HALF_CYC = 4;
  localparam int unsigned CS_GAP_CYC = 8;
  localparam int unsigned WAKE_BLANK_CYC = 4;
  localparam int unsigned STATUS_GAP_MS = 10;
  localparam int unsigned STATUS_GAP_MAX_MS = 20;
  localparam int unsigned STATUS_GAP_CYC = STATUS_GAP_MS * (CLK_HZ / 1000);
  localparam int unsigned REFRESH_MS = 100;
  localparam int unsigned REFRESH_CYC = REFRESH_MS * (CLK_HZ / 1000);
  typedef enum logic [1:0] {CAUSE_NONE, CAUSE_SPI, CAUSE_SWITCH, CAUSE_LINE} swm_cause_t;
  typedef enum logic {MODE_NORMAL, MODE_SLEEP} swm_mode_t;
  localparam swm_mode_t MODE_RESET = MODE_NORMAL;
  localparam swm_cause_t CAUSE_RESET = CAUSE_NONE;
endpackage

// [rtl/swm_link_if.sv]
/*
  swm_link_if: serial link and shared wake line between host and device.
  Assumes the testbench drives wake_ext_low for other devices on the line.
*/
`timescale 1ns/1ps
interface swm_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic wake_o;
  logic wake_oe;
  logic wake_ext_low;
  logic wake_line;
  // open line with pull-up: low when any party pulls it
  assign wake_line = ~((wake_oe & ~wake_o) | wake_ext_low);
  modport dev (input cs_n, input sclk, input mosi, input wake_line, output miso,
    output wake_o, output wake_oe);
  modport host (output cs_n, output sclk, output mosi, input miso, input wake_line);
endinterface

// [rtl/swm_device.sv]
/*
  swm_device: sleep/wake mode control of one switch monitor device, with a
  24-bit serial shift path and an open wake line.
  Assumes link pins come from another domain and are synchronised here.
*/
`timescale 1ns/1ps
// How it works
// - sleep command enters sleep at select rise
// - wake high in sleep, low normally
// - woken device pulls line; low line wakes
// - switch change in sleep wakes device
// - select falling edge wakes device
// - status command wakes; first status unreliable
// - change during sleep frame blocks sleep
// - two chained devices need 48 clocks
// - prefer serial chain over parallel select
// - wait 10-20 ms between status commands; host waits 10 ms only inside recovery, else 8 clocks
// - configure and acknowledge before sleep command
// - reset gives normal mode, host refreshes
// - wake cause flag readable over serial
module swm_device
  import swm_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  swm_link_if.dev link,
  input wire logic [N_GND-1:0] ground_switch_input,
  input wire logic [N_PROG-1:0] programmable_switch_input,
  output logic sleep_mode_q,
  output logic [1:0] wake_cause_q
);
  localparam logic [2:0] BLANK_LOAD = 3'(WAKE_BLANK_CYC);

  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;
  logic [1:0] pin_prev_q;
  logic [N_SW-1:0] sw_meta_q;
  logic [N_SW-1:0] sw_sync_q;
  logic [N_SW-1:0] sw_prev_q;
  logic [WORD_BITS-1:0] shift_q;
  logic miso_q;
  logic chg_frame_q;
  logic [2:0] blank_q;
  logic [2:0] blank_d;
  swm_mode_t mode_q;
  swm_mode_t mode_d;
  swm_cause_t cause_q;
  swm_cause_t cause_d;
  logic wake_oe_q;
  logic wake_o_q;

  wire cs_s = pin_sync_q[0];
  wire sclk_s = pin_sync_q[1];
  wire mosi_s = pin_sync_q[2];
  wire line_s = pin_sync_q[3];
  wire cs_fall = pin_prev_q[0] & ~cs_s;
  wire cs_rise = ~pin_prev_q[0] & cs_s;
  wire sclk_rise = ~pin_prev_q[1] & sclk_s & ~cs_s;
  wire sw_change = (sw_sync_q != sw_prev_q);
  wire asleep = (mode_q == MODE_SLEEP);
  wire [7:0] cmd = shift_q[CMD_MSB:CMD_LSB];
  wire cmd_sleep = cs_rise & (cmd == CMD_SLEEP);
  wire cmd_status = cs_rise & (cmd == CMD_STATUS);
  // a change seen any time in the frame, even on the closing cycle, vetoes sleep
  wire sleep_veto = chg_frame_q | sw_change;
  wire enter_sleep = ~asleep & cmd_sleep & ~sleep_veto;
  wire wake_cs = asleep & (cs_fall | cmd_status);
  wire wake_sw = asleep & sw_change;
  // ignore the line until our own release has settled through the synchroniser
  wire wake_line = asleep & ~line_s & (blank_q == 3'h0);
  wire wake_any = wake_cs | wake_sw | wake_line;
  wire [WORD_BITS-1:0] status_word = {cause_q, sw_sync_q};

  // pin synchronisers
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      // idle levels: select high, clock, data and pulled line low
      pin_meta_q <= 4'h1;
      pin_sync_q <= 4'h1;
      pin_prev_q <= 2'h1;
      sw_meta_q <= '0;
      sw_sync_q <= '0;
      sw_prev_q <= '0;
    end
    else
    begin
      pin_meta_q <= {link.wake_line, link.mosi, link.sclk, link.cs_n};
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q[1:0];
      sw_meta_q <= {programmable_switch_input, ground_switch_input};
      sw_sync_q <= sw_meta_q;
      sw_prev_q <= sw_sync_q;
    end
  end

  // shift path, out on the top bit
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      shift_q <= '0;
      miso_q <= 1'b0;
    end
    else if (cs_fall)
    begin
      shift_q <= status_word;
      miso_q <= status_word[WORD_BITS-1];
    end
    else if (sclk_rise)
    begin
      shift_q <= {shift_q[WORD_BITS-2:0], mosi_s};
      miso_q <= shift_q[WORD_BITS-2];
    end
  end

  // switch change while select is low
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      chg_frame_q <= 1'b0;
    end
    else if (cs_fall)
    begin
      chg_frame_q <= sw_change;
    end
    else if (~cs_s & sw_change)
    begin
      chg_frame_q <= 1'b1;
    end
  end

  // mode, blanking and wake cause
  always_comb
  begin
    mode_d = mode_q;
    blank_d = blank_q;
    cause_d = cause_q;
    if (blank_q != 3'h0)
    begin
      blank_d = blank_q - 3'h1;
    end
    if (cs_fall)
    begin
      cause_d = CAUSE_NONE;
    end
    if (enter_sleep)
    begin
      mode_d = MODE_SLEEP;
      blank_d = BLANK_LOAD;
    end
    else if (wake_any)
    begin
      mode_d = MODE_NORMAL;
      // a wake event wins over the clear on read
      if (wake_sw)
      begin
        cause_d = CAUSE_SWITCH;
      end
      else if (wake_line)
      begin
        cause_d = CAUSE_LINE;
      end
      else
      begin
        cause_d = CAUSE_SPI;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      mode_q <= MODE_RESET;
      cause_q <= CAUSE_RESET;
      blank_q <= 3'h0;
    end
    else
    begin
      mode_q <= mode_d;
      cause_q <= cause_d;
      blank_q <= blank_d;
    end
  end

  // open wake output: pull low in normal mode, release in sleep
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      wake_oe_q <= 1'b1;
      wake_o_q <= 1'b0;
    end
    else
    begin
      wake_oe_q <= (mode_d == MODE_NORMAL);
      wake_o_q <= (mode_d == MODE_SLEEP);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      sleep_mode_q <= 1'b0;
      wake_cause_q <= 2'h0;
    end
    else
    begin
      sleep_mode_q <= (mode_d == MODE_SLEEP);
      wake_cause_q <= cause_d;
    end
  end

  assign link.miso = miso_q;
  assign link.wake_o = wake_o_q;
  assign link.wake_oe = wake_oe_q;
endmodule

// [verif/swm_link_checker.sv]
/*
  swm_link_checker: concurrent checks on the serial link and the wake line.
  Assumes the bench instantiates it beside the link interface.
*/
`timescale 1ns/1ps
module swm_link_checker
#(
  parameter int unsigned N_DEV = 2
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic wake_o,
  input wire logic wake_oe,
  input wire logic wake_ext_low,
  input wire logic wake_line
);
  localparam int RISES = 24 * N_DEV;
  logic sclk_q;
  logic [7:0] rises_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // serial clock rises within the current frame
  always_ff @(posedge clk)
  begin
    sclk_q <= sclk;
    if (!reset_n || cs_n)
      rises_q <= 8'h00;
    else if (sclk && !sclk_q)
      rises_q <= rises_q + 8'h01;
  end
  chk_wake_level: assert property (wake_oe != wake_o)
    else $error("wake output and enable disagree");
  chk_sleep_at_rise: assert property ($fell(wake_oe) |->
    cs_n && $past(cs_n, 3) && !$past(cs_n, 4))
    else $error("sleep entered away from select rise");
  chk_line_wakes: assert property ($rose(wake_ext_low) && !wake_oe && !$past(wake_oe, 6)
    |-> ##[1:6] wake_oe)
    else $error("low wake line did not wake device");
  chk_woken_pulls: assert property ($rose(wake_oe) |-> !wake_line)
    else $error("woken device left wake line high");
  chk_select_wakes: assert property ($fell(cs_n) && !wake_oe |-> ##[1:6] wake_oe)
    else $error("select fall did not wake device");
  chk_frame_clocks: assert property ($rose(cs_n) |-> rises_q == RISES)
    else $error("wrong clock count in frame");
  chk_sclk_half: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("serial clock high phase wrong");
  chk_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock runs outside frame");
  chk_mosi_hold: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("data changed while clock high");
  chk_cs_gap: assert property ($rose(cs_n) |-> cs_n[*8])
    else $error("select gap too short");
endmodule

// [verif/tb.sv]
/*
  tb: host and one device joined by the link interface; sleep, wake,
  refusal, recovery, refresh and reset cases.
  Assumes short gap and refresh counts set as host parameters.
*/
`timescale 1ns/1ps
module tb;
  import swm_pkg::*;
  localparam int GAP = 20;
  localparam int REFR = 50;
  // row: wake method in [3:2], expected cause in [1:0]
  localparam logic [3:0] ROWS [3] = '{4'h1, 4'h6, 4'hB};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic frame_req = 1'b0;
  logic sleep_req = 1'b0;
  logic acked_all = 1'b1;
  logic recover_req = 1'b0;
  logic [WORD_BITS-1:0] frame_data = {CMD_STATUS, CMD_PAD};
  logic [N_GND-1:0] gnd = 14'h2A5B;
  logic [N_PROG-1:0] prog = 8'hC3;
  logic busy_q, done_q, wake_low_q, refresh_due_q, sleep_mode_q;
  logic [WORD_BITS-1:0] rx_data_q;
  logic [1:0] wake_cause_q;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int dones, gap, refr;
  swm_link_if link();
  initial link.wake_ext_low = 1'b0;
  swm_host #(.N_DEV(1), .HALF_CYC(4), .GAP_CYC(GAP), .REFR_CYC(REFR)) swm_host_i (
    .clk(clk), .reset_n(reset_n), .link(link), .frame_req(frame_req),
    .frame_data(frame_data), .sleep_req(sleep_req), .acked_all(acked_all),
    .recover_req(recover_req), .busy_q(busy_q), .done_q(done_q), .rx_data_q(rx_data_q),
    .wake_low_q(wake_low_q), .refresh_due_q(refresh_due_q));
  swm_device swm_device_i (.clk(clk), .reset_n(reset_n), .link(link),
    .ground_switch_input(gnd), .programmable_switch_input(prog),
    .sleep_mode_q(sleep_mode_q), .wake_cause_q(wake_cause_q));
  swm_link_checker #(.N_DEV(1)) swm_link_checker_i (.clk(clk), .reset_n(reset_n),
    .cs_n(link.cs_n), .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso),
    .wake_o(link.wake_o), .wake_oe(link.wake_oe), .wake_ext_low(link.wake_ext_low),
    .wake_line(link.wake_line));

  always #25 clk = ~clk;

  task automatic finish_test;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      finish_test;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      checked++;
      if (seen !== exp)
      begin
        mismatches++;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task automatic tick(input int n);
    begin
      repeat (n) @(posedge clk);
      #5;
    end
  endtask

  // kind 0 status frame, 1 sleep, 2 two-step recovery
  task automatic go(input int kind);
    int n;
    begin
      n = 0;
      dones = 0;
      gap = 0;
      frame_req = (kind == 0);
      sleep_req = (kind == 1);
      recover_req = (kind == 2);
      while (busy_q !== 1'b1 && n < 50)
      begin
        tick(1);
        n++;
      end
      frame_req = 1'b0;
      sleep_req = 1'b0;
      recover_req = 1'b0;
      while ((dones < 1 + (kind == 2) || busy_q !== 1'b0) && n < 3000)
      begin
        tick(1);
        n++;
        if (done_q === 1'b1)
          dones++;
        if (dones == 1 && link.cs_n === 1'b1)
          gap++;
      end
      chk(n < 3000, 1);
    end
  endtask

  initial
  begin
    tick(8);
    chk({sleep_mode_q, wake_cause_q, link.wake_oe, link.cs_n}, 5'h03);
    reset_n = 1'b1;
    tick(3);
    for (int r = 0; r < 3; r++)
    begin
      go(1);
      chk(sleep_mode_q, 1);
      chk(link.wake_line, 1);
      chk(wake_low_q, 0);
      case (ROWS[r][3:2])
        2'h0: go(0);
        2'h1: gnd[0] = ~gnd[0];
        default: link.wake_ext_low = 1'b1;
      endcase
      tick(10);
      link.wake_ext_low = 1'b0;
      chk(sleep_mode_q, 0);
      chk(link.wake_line, 0);
      chk(wake_low_q, 1);
      chk(wake_cause_q, ROWS[r][1:0]);
      go(0);
      chk(rx_data_q, {ROWS[r][1:0], prog, gnd});
    end
    fork
      go(1);
      begin
        tick(60);
        gnd[5] = ~gnd[5];
      end
    join
    tick(6);
    chk(sleep_mode_q, 0);
    acked_all = 1'b0;
    sleep_req = 1'b1;
    tick(10);
    chk({busy_q, sleep_mode_q}, 2'h0);
    sleep_req = 1'b0;
    acked_all = 1'b1;
    tick(2);
    go(2);
    chk(dones, 2);
    chk(gap >= GAP, 1);
    chk(rx_data_q[21:0], {prog, gnd});
    refr = 0;
    repeat (200)
    begin
      tick(1);
      refr += (refresh_due_q === 1'b1);
    end
    chk(refr, 200 / REFR);
    go(1);
    reset_n = 1'b0;
    tick(4);
    chk({sleep_mode_q, wake_cause_q, link.wake_oe}, 4'h1);
    reset_n = 1'b1;
    tick(4);
    go(0);
    chk(rx_data_q[23:22], 0);
    finish_test;
  end
endmodule
